/* File: hdl/kwu_keypad_wake_unit.sv */
// Keypad wake unit sharing an eight-line port, APB register slave
// Overview of operation
// [RULE_01] One select bit per port line
// [RULE_02] Selected lines forced to input direction
// [RULE_03] Edge-only or edge-and-level detection mode
// [RULE_04] Lines 3..0 falling edge or low level
// [RULE_05] Lines 7..4 have a polarity select
// [RULE_06] Pull bit acts only on input lines
// [RULE_07] Rising polarity turns pullup into pulldown
// [RULE_08] Keypad event wakes from wait and standby
// [RULE_09] One shared flag and one enable
// [RULE_10] Edge is consecutive samples high-low or low-high
// [RULE_11] Interrupt when flag and enable both set
// [RULE_12] Clear by write one, level holds flag
// [RULE_13] Stop mode: asynchronous level wake path
// [RULE_14] Two-stage synchroniser on every pin input
//
// The APB slave port and the address map were chosen for this implementation.
module kwu_keypad_wake_unit (
  // Clock and reset
  input  wire  logic              clk,
  input  wire  logic              rst,
  // APB slave
  input  wire  logic              psel,
  input  wire  logic              penable,
  input  wire  logic              pwrite,
  input  wire  logic [11:0]       paddr,
  input  wire  logic [31:0]       pwdata,
  input  wire  logic [3:0]        pstrb,
  output logic       [31:0]       prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Port pins
  input  wire  logic [7:0]        port_in,
  output logic       [7:0]        port_out,
  output logic       [7:0]        port_oe,
  output logic       [7:0]        pullup_en,
  output logic       [7:0]        pulldown_en,
  // Power mode and wake
  input  wire  logic              stop_mode,
  output logic                    keypad_irq,
  output logic                    wake_req
);
  logic [7:0] port_line_data_q;
  logic [7:0] port_line_direction_q;
  logic [7:0] port_line_pull_select_q;
  logic [7:0] keypad_pin_select_reg_q;
  logic [3:0] keypad_polarity_select_q;
  logic       keypad_detect_mode_q;
  logic       keypad_irq_enable_q;
  logic       keypad_event_flag_q;
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic [7:0] prev_asserted_q;
  logic [7:0] prdata_q;
  logic [7:0] active_high;
  logic [7:0] asserted;
  logic [7:0] raw_asserted;
  logic       edge_event;
  logic       level_hold;
  logic       wr_en;
  logic       rd_en;
  logic       addr_ok;
  logic       clear_req;
  logic       flag_set;
  logic [7:0] rise_lines;

  // Decode, strobes and read path
  logic       sel_ctrl;
  logic       sel_pin_select;
  logic       sel_data;
  logic       sel_direction;
  logic       sel_pull;
  logic       sel_pin_level;
  logic       wr_ctrl;
  logic       wr_pin_select;
  logic       wr_data;
  logic       wr_direction;
  logic       wr_pull;
  logic [7:0] ctrl_rd;
  logic [7:0] rd_mux;

  // Pin side helpers
  logic [7:0] pd_lines;
  logic [7:0] pu_lines;
  logic       wake_run;
  logic       wake_stop;

  // Per-line asserted level after polarity
  function automatic logic [7:0] asserted_of(input logic [7:0] lvl, input logic [7:0] hi);
    asserted_of = ~(lvl ^ hi);
  endfunction

  // Exact match of a bus address against one register offset
  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] off);
    reg_hit = (addr == off);
  endfunction

  // Upper lines select polarity, lower lines are always active low
  assign active_high  = {keypad_polarity_select_q, 4'h0};  // [RULE_04] [RULE_05]
  assign asserted     = asserted_of(sync2_q, active_high) & keypad_pin_select_reg_q;
  assign raw_asserted = asserted_of(port_in, active_high) & keypad_pin_select_reg_q;

  // Sync stage one feeds only stage two
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sync1_q <= kwu_pkg::RST_BYTE;
    else
      sync1_q <= port_in;  // [RULE_14]
  end

  // Stage two is the only stage the detector reads
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sync2_q <= kwu_pkg::RST_BYTE;
    else
      sync2_q <= sync1_q;  // [RULE_14]
  end

  // History of asserted state; a deselected line counts as deasserted
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prev_asserted_q <= kwu_pkg::RST_BYTE;
    else
      prev_asserted_q <= asserted;
  end

  // Deasserted then asserted in the next cycle is an edge
  assign rise_lines = asserted & ~prev_asserted_q;  // [RULE_10]
  assign edge_event = |rise_lines;
  assign level_hold = keypad_detect_mode_q & (|asserted);  // [RULE_03]

  // Set sources beat a clear in the same cycle
  assign flag_set   = edge_event | level_hold;  // [RULE_12]

  // APB decode
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~pwrite & ~penable;

  // One hit per mapped offset; holes change nothing
  assign sel_ctrl       = reg_hit(paddr, kwu_pkg::OFF_STATUS_CTRL);
  assign sel_pin_select = reg_hit(paddr, kwu_pkg::OFF_PIN_SELECT);
  assign sel_data       = reg_hit(paddr, kwu_pkg::OFF_DATA);
  assign sel_direction  = reg_hit(paddr, kwu_pkg::OFF_DIRECTION);
  assign sel_pull       = reg_hit(paddr, kwu_pkg::OFF_PULL);
  assign sel_pin_level  = reg_hit(paddr, kwu_pkg::OFF_PIN_LEVEL);
  assign addr_ok        = sel_ctrl | sel_pin_select | sel_data | sel_direction | sel_pull
                        | sel_pin_level;

  // Zero wait states: every transfer ends at its first access edge
  assign pready         = 1'b1;
  assign pslverr        = psel & penable & ~addr_ok;

  // Writes land at the access edge through byte lane 0 only
  assign wr_ctrl       = wr_en & pstrb[0] & sel_ctrl;
  assign wr_pin_select = wr_en & pstrb[0] & sel_pin_select;
  assign wr_data       = wr_en & pstrb[0] & sel_data;
  assign wr_direction  = wr_en & pstrb[0] & sel_direction;
  assign wr_pull       = wr_en & pstrb[0] & sel_pull;
  assign clear_req     = wr_ctrl & pwdata[kwu_pkg::BIT_CLEAR];  // [RULE_12]

  // Port data register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      port_line_data_q <= kwu_pkg::RST_BYTE;
    else if (wr_data)
      port_line_data_q <= pwdata[7:0];
  end

  // Port direction register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      port_line_direction_q <= kwu_pkg::RST_BYTE;
    else if (wr_direction)
      port_line_direction_q <= pwdata[7:0];
  end

  // Port pull register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      port_line_pull_select_q <= kwu_pkg::RST_BYTE;
    else if (wr_pull)
      port_line_pull_select_q <= pwdata[7:0];
  end

  // Keypad line select
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      keypad_pin_select_reg_q <= kwu_pkg::RST_BYTE;
    else if (wr_pin_select)
      keypad_pin_select_reg_q <= pwdata[7:0];  // [RULE_01]
  end

  // Upper line polarity
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      keypad_polarity_select_q <= kwu_pkg::RST_POL;
    else if (wr_ctrl)
      keypad_polarity_select_q <= pwdata[kwu_pkg::POL_LSB +: kwu_pkg::POL_W];  // [RULE_05]
  end

  // Detection mode
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      keypad_detect_mode_q <= 1'b0;
    else if (wr_ctrl)
      keypad_detect_mode_q <= pwdata[kwu_pkg::BIT_MODE];  // [RULE_03]
  end

  // Shared interrupt enable
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      keypad_irq_enable_q <= 1'b0;
    else if (wr_ctrl)
      keypad_irq_enable_q <= pwdata[kwu_pkg::BIT_IRQ_EN];  // [RULE_09]
  end

  // Shared flag: a new edge or a held level beats the clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      keypad_event_flag_q <= 1'b0;
    else if (flag_set)
      keypad_event_flag_q <= 1'b1;  // [RULE_09] [RULE_12]
    else if (clear_req)
      keypad_event_flag_q <= 1'b0;  // [RULE_12]
  end

  // Status byte; the clear bit always reads zero
  assign ctrl_rd = {keypad_polarity_select_q, keypad_event_flag_q, 1'b0, keypad_irq_enable_q,
                    keypad_detect_mode_q};

  // Read selection, holes read zero
  always_comb
  begin
    rd_mux = kwu_pkg::RST_BYTE;
    if (sel_ctrl)
      rd_mux = ctrl_rd;
    else if (sel_pin_select)
      rd_mux = keypad_pin_select_reg_q;
    else if (sel_data)
      rd_mux = port_line_data_q;
    else if (sel_direction)
      rd_mux = port_line_direction_q;
    else if (sel_pull)
      rd_mux = port_line_pull_select_q;
    else if (sel_pin_level)
      rd_mux = sync2_q;
  end

  // Latched in the setup phase so it stands through the access phase
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prdata_q <= kwu_pkg::RST_BYTE;
    else if (rd_en)
      prdata_q <= rd_mux;
  end

  // Registers are one byte wide
  assign prdata = {24'h000000, prdata_q};

  // Pin drive; a selected line never drives
  assign port_out = port_line_data_q;
  assign port_oe  = port_line_direction_q & ~keypad_pin_select_reg_q;  // [RULE_02]

  // Pulls act on inputs only; a selected rising line pulls down instead
  always_comb
  begin
    pd_lines = 8'h00;
    pu_lines = 8'h00;
    for (int i = 0; i < kwu_pkg::PORT_W; i++)
    begin
      if (port_line_pull_select_q[i] && !port_oe[i])
      begin
        if (keypad_pin_select_reg_q[i] && active_high[i])
          pd_lines[i] = 1'b1;  // [RULE_07]
        else
          pu_lines[i] = 1'b1;  // [RULE_06]
      end
    end
  end

  // Pull outputs
  assign pulldown_en = pd_lines;
  assign pullup_en   = pu_lines;

  // Interrupt request follows the shared flag when enabled
  assign keypad_irq = keypad_event_flag_q & keypad_irq_enable_q;  // [RULE_11]

  // Clock may be stopped in stop mode, so that wake path uses raw pin levels
  assign wake_run  = keypad_event_flag_q;  // [RULE_08]
  assign wake_stop = |raw_asserted;  // [RULE_13]
  assign wake_req  = keypad_irq_enable_q & (stop_mode ? wake_stop : wake_run);
endmodule

/* File: hdl/kwu_pkg.sv */
// Constants for the keypad wake unit and its shared port
package kwu_pkg;
  localparam int unsigned PORT_W          = 8;
  // Register byte offsets on APB
  localparam logic [11:0] OFF_STATUS_CTRL = 12'h000;
  localparam logic [11:0] OFF_PIN_SELECT  = 12'h004;
  localparam logic [11:0] OFF_DATA        = 12'h008;
  localparam logic [11:0] OFF_DIRECTION   = 12'h00c;
  localparam logic [11:0] OFF_PULL        = 12'h010;
  localparam logic [11:0] OFF_PIN_LEVEL   = 12'h014;
  // Status and control field positions
  localparam int unsigned BIT_MODE        = 0;
  localparam int unsigned BIT_IRQ_EN      = 1;
  localparam int unsigned BIT_CLEAR       = 2;
  localparam int unsigned BIT_FLAG        = 3;
  localparam int unsigned POL_LSB         = 4;
  localparam int unsigned POL_W           = 4;
  // Reset values
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [3:0]  RST_POL         = 4'h0;
endpackage

/* File: verif/kwu_sva.sv */
// Port checker for the keypad wake unit
module kwu_sva (
  // Clock, reset and APB
  input wire logic        clk, rst, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  // Pins and wake
  input wire logic [7:0]  port_oe, pullup_en, pulldown_en,
  input wire logic        stop_mode, keypad_irq, wake_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_setup: assert property (psel && !penable |-> !pslverr) else $error("early slverr");
  a_err_unmapped: assert property (psel && penable && paddr > 12'h014 |-> pslverr
    && (pwrite || prdata == 32'h0)) else $error("unmapped access");
  a_rdata_upper: assert property (prdata[31:8] == 24'h0) else $error("prdata upper bits");
  a_rdata_hold: assert property (!psel |=> $stable(prdata)) else $error("prdata moved");
  a_irq_wake: assert property (!stop_mode |-> wake_req == keypad_irq) else $error("wake");
  a_pull_excl: assert property ((pullup_en & pulldown_en) == 8'h00) else $error("pulls");
  a_pull_input: assert property (((pullup_en | pulldown_en) & port_oe) == 8'h00)
    else $error("pull on output");
  a_pd_lower: assert property (pulldown_en[3:0] == 4'h0) else $error("lower pulldown");
endmodule
bind kwu_keypad_wake_unit kwu_sva u_sva (.clk, .rst, .psel, .penable, .pwrite, .pready,
  .pslverr, .paddr, .prdata, .port_oe, .pullup_en, .pulldown_en, .stop_mode, .keypad_irq,
  .wake_req);

/* File: verif/kwu_pins.sv */
// Switch and pull model standing on the port lines
module kwu_pins (
  input  wire logic       clk,
  input  wire logic [7:0] sw_en, sw_lvl, port_out, port_oe, pullup_en, pulldown_en,
  output logic      [7:0] port_in
);
  // Floating lines toggle so a stale value never looks valid
  logic tog = 1'b0;
  always @(posedge clk) tog <= ~tog;
  always_comb
    for (int i = 0; i < 8; i++)
      port_in[i] = port_oe[i] ? port_out[i] : sw_en[i] ? sw_lvl[i] :
        pullup_en[i] ? 1'b1 : pulldown_en[i] ? 1'b0 : tog;
endmodule

/* File: verif/keypad_wake_interrupt_bench.sv */
// Self-checking bench for the keypad wake unit
module keypad_wake_interrupt_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, stop_mode = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, pslverr, keypad_irq, wake_req;
  logic [7:0]  port_in, port_out, port_oe, pullup_en, pulldown_en, sw_en = 0, sw_lvl = 0;
  int          errors = 0, checks_done = 0;
  always #4 clk = ~clk;
  kwu_keypad_wake_unit u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .port_in, .port_out, .port_oe, .pullup_en, .pulldown_en,
    .stop_mode, .keypad_irq, .wake_req);
  kwu_pins u_pins (.clk, .sw_en, .sw_lvl, .port_out, .port_oe, .pullup_en, .pulldown_en,
    .port_in);
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_reset();
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 12'h040, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
  endtask
  task automatic t_gpio();
    apb(1'b1, kwu_pkg::OFF_DIRECTION, 32'hff);
    apb(1'b1, kwu_pkg::OFF_DATA, 32'ha5);
    apb(1'b1, kwu_pkg::OFF_PIN_SELECT, 32'h0f);
    @(posedge clk);
    chk({port_oe, port_out}, 16'hf0a5);
  endtask
  task automatic t_pull();
    apb(1'b1, kwu_pkg::OFF_DIRECTION, 32'h0);
    apb(1'b1, kwu_pkg::OFF_PULL, 32'hff);
    apb(1'b1, kwu_pkg::OFF_STATUS_CTRL, 32'hf0);
    apb(1'b1, kwu_pkg::OFF_PIN_SELECT, 32'hf0);
    @(posedge clk);
    chk({pulldown_en, pullup_en}, 16'hf00f);
  endtask
  task automatic ctl(input logic [31:0] w, input logic [31:0] exp);
    if (w != 0) apb(1'b1, kwu_pkg::OFF_STATUS_CTRL, w);
    apb(1'b0, kwu_pkg::OFF_STATUS_CTRL, 32'h0);
    chk(rd, exp);
  endtask
  task automatic t_edge();
    sw_en <= 8'hff;
    sw_lvl <= 8'h0f;
    apb(1'b1, kwu_pkg::OFF_PIN_SELECT, 32'hff);
    ctl(32'hf6, 32'hf2);
    sw_lvl <= 8'h0e;
    repeat (4) @(posedge clk);
    ctl(32'h0, 32'hfa);
    chk(keypad_irq, 1'b1);
    ctl(32'hf6, 32'hf2);
    sw_lvl <= 8'h1e;
    repeat (4) @(posedge clk);
    ctl(32'hf0, 32'hf8);
    chk(keypad_irq, 1'b0);
    ctl(32'hf7, 32'hfb);
    sw_lvl <= 8'h0f;
    repeat (4) @(posedge clk);
    ctl(32'hf7, 32'hf3);
    stop_mode <= 1'b1;
    sw_lvl <= 8'h0d;
    @(negedge clk);
    chk(wake_req, 1'b1);
  endtask
  initial
  begin
    #20us;
    errors++;
    results();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_gpio();
    t_pull();
    t_edge();
    results();
  end
endmodule
